// *** core/irq_flags_pkg.sv ***
// Package: register map, flag positions and reset values of the I2C event flag block
package irq_flags_pkg;
    localparam logic [31:0] STATUS_ADDR = 32'h5000_132c;
    localparam logic [31:0] MASK_ADDR = 32'h5000_1330;
    localparam int FIFO_DEPTH = 32;
    localparam int LVL_W = 6;
    localparam int BIT_RX_UNDER = 0;
    localparam int BIT_RX_OVER = 1;
    localparam int BIT_RX_FULL = 2;
    localparam int BIT_TX_OVER = 3;
    localparam int BIT_TX_EMPTY = 4;
    localparam int BIT_RD_REQ = 5;
    localparam int BIT_TX_ABRT = 6;
    localparam int BIT_TX_DONE = 7;
    localparam logic [15:0] MASK_RESET = 16'h08ff;
    localparam logic [15:0] MASK_WRITABLE = 16'h0fff;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [15:0] ABORT_REASON_RESET = 16'h0000;

    // Hardware events from the bus engines and FIFO side
    typedef struct packed {
        logic tx_nack_last;
        logic tx_abort;
        logic [15:0] abort_reason;
        logic rd_req;
        logic tx_push;
        logic rx_push;
        logic rx_pop;
    } hw_events_t;

    // Register access strobes from the APB side
    typedef struct packed {
        logic wr;
        logic rd;
        logic [31:0] addr;
        logic [15:0] wdata;
        logic clr_tx_abrt_rd;
        logic clr_rd_req_rd;
    } reg_access_t;
endpackage : irq_flags_pkg

// *** core/irq_flags.sv ***
// Event flags, mask register and interrupt output of the I2C controller
`timescale 1ns/1ns

//
// Contract
// - Slave-transmit NACK sets transmit-done flag
// - Transmit abort sets flag, records reason
// - Abort flag flushes TX FIFO until cleared
// - Read request sets flag, holds SCL low
// - Read of clear register drops read request
// - TX empty when level at/below threshold
// - Disabled: TX flushed, empty follows activity
// - Write at 32 entries sets TX overflow
// - Overflow/underflow held until internal enable drops
// - RX full when level at/above threshold
// - Disable flushes RX, clears RX full
// - Push at 32 bytes: ack, drop, overflow
// - Read of empty RX sets underflow
// - Mask bits 11:0 writable, only 7:0 gate flags; 15:12 zero
// - Mask reset: 0x08ff pattern
module irq_flags #(
    parameter int DEPTH = irq_flags_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic nrst,
    input wire irq_flags_pkg::hw_events_t ev,
    input wire irq_flags_pkg::reg_access_t acc,
    input wire logic enable,
    input wire logic internal_enable_signal,
    input wire logic engines_active,
    input wire logic [5:0] tx_threshold_reg,
    input wire logic [5:0] rx_threshold_reg,
    input wire logic [5:0] tx_level,
    input wire logic [5:0] rx_level,
    output logic [15:0] rdata,
    output logic [15:0] abort_reason_reg,
    output logic tx_flush,
    output logic rx_flush,
    output logic tx_drop,
    output logic rx_drop,
    output logic scl_hold_n,
    output logic irq
);
    logic [7:0] flags_r, flags_nxt;
    logic [15:0] mask_r, mask_nxt;
    logic [15:0] reason_r, reason_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic tx_flush_r, tx_flush_nxt;
    logic rx_flush_r, rx_flush_nxt;
    logic tx_drop_r, tx_drop_nxt;
    logic rx_drop_r, rx_drop_nxt;
    logic scl_hold_n_r, scl_hold_n_nxt;
    logic irq_r, irq_nxt;
    logic [15:0] status_now;
    logic tx_full_push;
    logic rx_full_push;
    logic rx_empty_pop;

    function automatic logic [15:0] widen(input logic [7:0] f);
        widen = {8'h00, f};
    endfunction : widen

    // Address match of a register access
    function automatic logic hit(input logic [31:0] a, input logic [31:0] where);
        hit = (a == where);
    endfunction : hit

    // Pushes into a full FIFO and pops from an empty one
    assign tx_full_push = ev.tx_push && (tx_level >= 6'(DEPTH));
    assign rx_full_push = ev.rx_push && (rx_level >= 6'(DEPTH));
    assign rx_empty_pop = ev.rx_pop && (rx_level == 6'h00);

    // Event flags
    always_comb begin
        flags_nxt = flags_r;
        // Hardware-driven sticky flags: set wins over clear
        if (acc.clr_rd_req_rd) begin
            flags_nxt[irq_flags_pkg::BIT_RD_REQ] = 1'b0;
        end
        if (ev.rd_req) begin
            flags_nxt[irq_flags_pkg::BIT_RD_REQ] = 1'b1;
        end
        if (acc.clr_tx_abrt_rd) begin
            flags_nxt[irq_flags_pkg::BIT_TX_ABRT] = 1'b0;
        end
        if (ev.tx_abort) begin
            flags_nxt[irq_flags_pkg::BIT_TX_ABRT] = 1'b1;
        end
        if (ev.tx_nack_last) begin
            flags_nxt[irq_flags_pkg::BIT_TX_DONE] = 1'b1;
        end
        // Error flags clear only when the internal enable has fallen
        if (!internal_enable_signal) begin
            flags_nxt[irq_flags_pkg::BIT_TX_OVER] = 1'b0;
            flags_nxt[irq_flags_pkg::BIT_RX_OVER] = 1'b0;
            flags_nxt[irq_flags_pkg::BIT_RX_UNDER] = 1'b0;
        end
        if (tx_full_push) begin
            flags_nxt[irq_flags_pkg::BIT_TX_OVER] = 1'b1;
        end
        if (rx_full_push) begin
            flags_nxt[irq_flags_pkg::BIT_RX_OVER] = 1'b1;
        end
        if (rx_empty_pop) begin
            flags_nxt[irq_flags_pkg::BIT_RX_UNDER] = 1'b1;
        end
        // Level flags follow the FIFO fill every cycle while enabled
        if (!enable) begin
            flags_nxt[irq_flags_pkg::BIT_TX_EMPTY] = engines_active;
            flags_nxt[irq_flags_pkg::BIT_RX_FULL] = 1'b0;
        end else begin
            flags_nxt[irq_flags_pkg::BIT_TX_EMPTY] = (tx_level <= tx_threshold_reg);
            flags_nxt[irq_flags_pkg::BIT_RX_FULL] = (rx_level >= rx_threshold_reg);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flags_r <= irq_flags_pkg::FLAGS_RESET;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // Mask register, reserved bits dropped on write
    always_comb begin
        mask_nxt = mask_r;
        if (acc.wr && hit(acc.addr, irq_flags_pkg::MASK_ADDR)) begin
            mask_nxt = acc.wdata & irq_flags_pkg::MASK_WRITABLE;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mask_r <= irq_flags_pkg::MASK_RESET;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    // Abort cause captured with the abort flag
    always_comb begin
        reason_nxt = reason_r;
        if (ev.tx_abort) begin
            reason_nxt = ev.abort_reason;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reason_r <= irq_flags_pkg::ABORT_REASON_RESET;
        end else begin
            reason_r <= reason_nxt;
        end
    end

    assign status_now = widen(flags_r) & mask_r;

    // Read data stands one cycle after the access, zero otherwise
    always_comb begin
        rdata_nxt = 16'h0000;
        if (acc.rd && hit(acc.addr, irq_flags_pkg::STATUS_ADDR)) begin
            rdata_nxt = status_now;
        end else if (acc.rd && hit(acc.addr, irq_flags_pkg::MASK_ADDR)) begin
            rdata_nxt = mask_r;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // FIFO control, bus stretch and interrupt line
    always_comb begin
        tx_flush_nxt = flags_nxt[irq_flags_pkg::BIT_TX_ABRT] || !enable;
        rx_flush_nxt = !enable;
        tx_drop_nxt = tx_full_push;
        rx_drop_nxt = rx_full_push;
        // Stretch SCL until the read request is serviced
        scl_hold_n_nxt = !flags_nxt[irq_flags_pkg::BIT_RD_REQ];
        irq_nxt = |(widen(flags_nxt) & mask_nxt);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_flush_r <= 1'b0;
            rx_flush_r <= 1'b0;
            tx_drop_r <= 1'b0;
            rx_drop_r <= 1'b0;
            scl_hold_n_r <= 1'b1;
            irq_r <= 1'b0;
        end else begin
            tx_flush_r <= tx_flush_nxt;
            rx_flush_r <= rx_flush_nxt;
            tx_drop_r <= tx_drop_nxt;
            rx_drop_r <= rx_drop_nxt;
            scl_hold_n_r <= scl_hold_n_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign rdata = rdata_r;
    assign abort_reason_reg = reason_r;
    assign tx_flush = tx_flush_r;
    assign rx_flush = rx_flush_r;
    assign tx_drop = tx_drop_r;
    assign rx_drop = rx_drop_r;
    assign scl_hold_n = scl_hold_n_r;
    assign irq = irq_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    tx_done_set_a: assert property (
        ev.tx_nack_last |=> flags_r[7])
        else $error("transmit done not set");

    abort_set_a: assert property (
        ev.tx_abort |=> flags_r[6] && reason_r == $past(ev.abort_reason))
        else $error("abort flag or reason wrong");

    reason_hold_a: assert property (
        !ev.tx_abort |=> $stable(reason_r))
        else $error("abort reason changed without abort");

    abort_flush_a: assert property (
        flags_r[6] |-> tx_flush)
        else $error("tx not flushed during abort");

    abort_clear_a: assert property (
        acc.clr_tx_abrt_rd && !ev.tx_abort |=> !flags_r[6])
        else $error("abort flag not cleared");

    rdreq_hold_a: assert property (
        ev.rd_req |=> !scl_hold_n)
        else $error("scl not held on read request");

    rdreq_stretch_a: assert property (
        scl_hold_n == !flags_r[5])
        else $error("scl hold differs from read request");

    rdreq_clear_a: assert property (
        acc.clr_rd_req_rd && !ev.rd_req |=> !flags_r[5])
        else $error("read request not cleared");

    tx_empty_a: assert property (
        enable |=> flags_r[4] == ($past(tx_level) <= $past(tx_threshold_reg)))
        else $error("tx empty wrong");

    tx_empty_off_a: assert property (
        !enable |=> flags_r[4] == $past(engines_active))
        else $error("tx empty wrong while disabled");

    tx_over_a: assert property (
        ev.tx_push && tx_level >= 6'd32 |=> flags_r[3] && tx_drop)
        else $error("tx overflow not set");

    tx_drop_a: assert property (
        !(ev.tx_push && tx_level >= 6'd32) |=> !tx_drop)
        else $error("tx drop without overflow");

    err_clear_a: assert property (
        !internal_enable_signal && !ev.rx_pop && !ev.rx_push && !ev.tx_push
        |=> !flags_r[0] && !flags_r[1] && !flags_r[3])
        else $error("error flags not cleared");

    err_hold_a: assert property (
        internal_enable_signal && flags_r[3] |=> flags_r[3])
        else $error("tx overflow lost while enabled");

    rx_full_a: assert property (
        enable |=> flags_r[2] == ($past(rx_level) >= $past(rx_threshold_reg)))
        else $error("rx full wrong");

    rx_full_off_a: assert property (
        !enable |=> !flags_r[2] && rx_flush)
        else $error("rx full not cleared on disable");

    rx_over_a: assert property (
        ev.rx_push && rx_level >= 6'd32 |=> flags_r[1] && rx_drop)
        else $error("rx overflow not set");

    rx_under_a: assert property (
        ev.rx_pop && rx_level == 6'd0 |=> flags_r[0])
        else $error("underflow not set");

    mask_rsv_a: assert property (
        mask_r[15:12] == 4'h0)
        else $error("reserved mask bits set");

    mask_write_a: assert property (
        acc.wr && acc.addr == 32'h5000_1330 |=> mask_r == ($past(acc.wdata) & 16'h0fff))
        else $error("mask write wrong");

    status_read_a: assert property (
        acc.rd && acc.addr == 32'h5000_132c
        |=> rdata == ({8'h00, $past(flags_r)} & $past(mask_r)))
        else $error("status read wrong");

    irq_out_a: assert property (
        irq == |({8'h00, flags_r} & mask_r))
        else $error("interrupt output wrong");

    // Main scenarios
    abort_cycle_c: cover property (ev.tx_abort ##[1:20] acc.clr_tx_abrt_rd);
    rdreq_cycle_c: cover property (ev.rd_req ##[1:20] acc.clr_rd_req_rd);
    rx_over_c: cover property (ev.rx_push && rx_level >= 6'd32);
    tx_over_c: cover property (ev.tx_push && tx_level >= 6'd32);
    irq_rise_c: cover property (!irq ##1 irq);
endmodule : irq_flags

// *** verif/i2c_remote.sv ***
// Remote bus device model: read request, byte push, final-byte NACK
`timescale 1ns/1ns
module i2c_remote (
    input wire logic clk,
    input wire logic scl_hold_n,
    output logic rd_req,
    output logic rx_push,
    output logic tx_nack_last,
    output int stall
);
    initial begin
        {tx_nack_last, rx_push, rd_req} = 3'h0;
        stall = 0;
    end
    // Kind 0 read request, 1 byte in, 2 NACK of last byte
    task automatic send(input int kind);
        @(negedge clk);
        {tx_nack_last, rx_push, rd_req} = 3'h1 << kind;
        @(negedge clk);
        {tx_nack_last, rx_push, rd_req} = 3'h0;
    endtask : send
    // Cycles the master waits with the clock held low
    always @(posedge clk) begin
        stall <= scl_hold_n ? stall : stall + 1;
    end
endmodule : i2c_remote

// *** verif/tb_top.sv ***
// Testbench of the event flag, mask and interrupt block
`timescale 1ns/1ns
module tb_top;
    localparam logic [31:0] SA = irq_flags_pkg::STATUS_ADDR;
    localparam logic [31:0] MA = irq_flags_pkg::MASK_ADDR;
    logic clk = 0, nrst = 0, en = 1, ien = 1, act = 0, rd_req, rx_push, nack;
    logic abt = 0, tpush = 0, pop = 0, wr = 0, rdv = 0, clr_ab = 0, clr_rd = 0;
    logic [5:0] ttl = 6'h00, rtl = 6'h04, tlv = 6'h01, rlv = 6'h00;
    logic [31:0] addr = 32'h0000_0000;
    logic [15:0] wdata = 16'h0000, rdata, reason;
    logic tx_flush, rx_flush, tx_drop, rx_drop, scl_hold_n, irq;
    int fail_count = 0, check_count = 0, stall;
    irq_flags_pkg::reg_access_t acc;
    irq_flags_pkg::hw_events_t ev;
    assign acc = {wr, rdv, addr, wdata, clr_ab, clr_rd};
    assign ev = {nack, abt, 16'h0005, rd_req, tpush, rx_push, pop};
    irq_flags irq_flags_i (.clk(clk), .nrst(nrst), .ev(ev), .acc(acc), .enable(en),
        .internal_enable_signal(ien), .engines_active(act), .tx_threshold_reg(ttl),
        .rx_threshold_reg(rtl), .tx_level(tlv), .rx_level(rlv), .rdata(rdata),
        .abort_reason_reg(reason), .tx_flush(tx_flush), .rx_flush(rx_flush),
        .tx_drop(tx_drop), .rx_drop(rx_drop), .scl_hold_n(scl_hold_n), .irq(irq));
    i2c_remote i2c_remote_i (.clk(clk), .scl_hold_n(scl_hold_n), .rd_req(rd_req),
        .rx_push(rx_push), .tx_nack_last(nack), .stall(stall));
    initial forever #10 clk = ~clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1;
        @(negedge clk);
        s = 0;
    endtask : pulse
    task automatic rd(input logic [31:0] a, input logic [15:0] e);
        @(negedge clk);
        rdv = 1;
        addr = a;
        @(negedge clk);
        rdv = 0;
        chk(rdata, e);
    endtask : rd
    task automatic wrt(input logic [31:0] a, input logic [15:0] d);
        @(negedge clk);
        wr = 1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 0;
    endtask : wrt
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    initial begin
        #100000;
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (16) @(negedge clk);
        nrst = 1;
        rd(MA, 16'h08ff);
        rd(SA, 16'h0000);
        wrt(MA, 16'hffff);
        rd(MA, 16'h0fff);
        rd(32'h5000_1340, 16'h0000);
        $display("register test done");
        i2c_remote_i.send(0);
        chk(scl_hold_n, 1'b0);
        chk(irq, 1'b1);
        rd(SA, 16'h0020);
        wrt(MA, 16'h0fdf);
        chk(irq, 1'b0);
        wrt(MA, 16'h0fff);
        pulse(tpush);
        pulse(clr_rd);
        chk(scl_hold_n, 1'b1);
        chk(16'(stall > 3), 16'h0001);
        chk(irq, 1'b0);
        pulse(abt);
        chk(tx_flush, 1'b1);
        chk(reason, 16'h0005);
        rd(SA, 16'h0040);
        pulse(clr_ab);
        chk(tx_flush, 1'b0);
        $display("event test done");
        tlv = 6'h00;
        rd(SA, 16'h0010);
        tlv = 6'h01;
        rd(SA, 16'h0000);
        rlv = 6'h04;
        rd(SA, 16'h0004);
        rlv = 6'h03;
        rd(SA, 16'h0000);
        rlv = 6'h04;
        en = 0;
        rd(SA, 16'h0000);
        chk({tx_flush, rx_flush}, 2'h3);
        act = 1;
        rd(SA, 16'h0010);
        {en, act, rlv, tlv} = {2'h0, 6'h20, 6'h20};
        pulse(tpush);
        chk(tx_drop, 1'b1);
        i2c_remote_i.send(1);
        chk(rx_drop, 1'b1);
        rlv = 6'h00;
        pulse(pop);
        tlv = 6'h01;
        rd(SA, 16'h000b);
        {en, act} = 2'h1;
        rd(SA, 16'h001b);
        {ien, act} = 2'h0;
        rd(SA, 16'h0000);
        {en, ien} = 2'h3;
        i2c_remote_i.send(2);
        rd(SA, 16'h0080);
        $display("level test done");
        complete_run();
    end
endmodule : tb_top
